//--- pkg/oag_mem_if.sv
// Byte memory port between the generator and its pointer memory
`timescale 1ns/1ps
`default_nettype none
interface oag_mem_if #(parameter int AW = 16);
   logic we;
   logic [AW-1:0] waddr;
   logic [7:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [7:0] rdata;
   modport ctl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

//--- pkg/oag_pkg.sv
// Types shared by the operand address generator files
package oag_pkg;
   typedef enum logic [3:0] {
      M_REG, M_IMM, M_DP, M_ABS, M_X0, M_XINC, M_DPX, M_DPY,
      M_ABSY, M_DPIND, M_DPXIND, M_DPINDY, M_ABSIND
   } mode_e;
   typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_RMW, OP_JUMP, OP_OTHER} opc_e;
   typedef enum logic [1:0] {S_IDLE, S_LO, S_HI} fsm_e;
endpackage

//--- pkg/oag_regs.svh
// Register indices, field positions and reset values of the address generator
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH
// Register indices; byte address is four times the index
`define OAG_IDX_CTRL 10'h000
`define OAG_IDX_OPERAND 10'h001
`define OAG_IDX_INDEX 10'h002
`define OAG_IDX_RESULT 10'h003
`define OAG_IDX_STATUS 10'h004
`define OAG_IDX_MEMADDR 10'h005
`define OAG_IDX_MEMDATA 10'h006
`define OAG_IDX_PAGE 10'h0E1
// Control word fields
`define OAG_CTRL_MODE_LSB 0
`define OAG_CTRL_OP_LSB 4
`define OAG_CTRL_PEN_BIT 8
`define OAG_CTRL_START_BIT 31
// Status word fields
`define OAG_ST_BUSY 0
`define OAG_ST_DONE 1
`define OAG_ST_ILLEGAL 2
`define OAG_ST_VALUE 3
`define OAG_ST_NOADDR 4
`define OAG_ST_RMW 5
`define OAG_ST_TARGET 6
// Reset values
`define OAG_PAGE_RST 8'h00
`define OAG_BYTE_RST 8'h00
`define OAG_WORD_RST 16'h0000
// Bus answers
`define OAG_RESP_OKAY 2'h0
`define OAG_RESP_SLVERR 2'h2
`endif

//--- rtl/oag_page_mem.sv
// Byte-wide data memory holding pointers for indirect modes
`timescale 1ns/1ps
`default_nettype none
module oag_page_mem #(
   parameter int AW = 16
) (
   input wire logic i_clk, // Core clock
   input wire logic i_ce, // Clock enable
   oag_mem_if.mem bus // Memory port
);
   logic [7:0] mem_q [0:(1<<AW)-1];
   logic [7:0] rdata_q;

   // Write port; no reset, contents are software's business
   always_ff @(posedge i_clk) begin
      if (i_ce && bus.we) begin
         mem_q[bus.waddr] <= bus.wdata;
      end
   end

   // Registered read, one cycle of latency
   always_ff @(posedge i_clk) begin
      if (i_ce && bus.re) begin
         rdata_q <= mem_q[bus.raddr];
      end
   end

   assign bus.rdata = rdata_q;
endmodule // oag_page_mem
`default_nettype wire

//--- rtl/operand_address_generator.sv
// Effective-address generator with AXI4-Lite register access
// Function
// RQ1 - Register mode generates no memory address
// RQ2 - Immediate mode uses second byte as value
// RQ3 - Page enable: page byte plus immediate byte
// RQ4 - Direct page: operand byte within selected page
// RQ5 - Absolute: second byte low, third byte high
// RQ6 - Absolute ignores page enable and page
// RQ7 - Read-modify-write allowed with absolute addressing
// RQ8 - X alone gives direct-page location
// RQ9 - Auto-increment: use X, then X+1, load/store
// RQ10 - Operand plus X within direct page
// RQ11 - Operand plus Y, same as X form
// RQ12 - Absolute address plus Y, full space
// RQ13 - Jump/call via direct-page two-byte pointer
// RQ14 - Pointer at operand plus X, then data
// RQ15 - Pointer at operand, then plus Y
// RQ16 - Jump target fetched from absolute address
// RQ17 - Page is high byte, offset low byte
// RQ18 - Direct-page sums and increment wrap mod 256
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.svh"
module operand_address_generator
   import oag_pkg::*;
#(
   parameter int MEM_AW = 16
) (
   input wire logic I_CLK, // Core clock
   input wire logic I_RST, // Synchronous reset, active high
   input wire logic I_CE, // Clock enable
   input wire logic [11:0] I_AWADDR, // Write address
   input wire logic I_AWVALID, // Write address valid
   output logic O_AWREADY, // Write address ready
   input wire logic [31:0] I_WDATA, // Write data
   input wire logic [3:0] I_WSTRB, // Write strobes
   input wire logic I_WVALID, // Write data valid
   output logic O_WREADY, // Write data ready
   output logic [1:0] O_BRESP, // Write response
   output logic O_BVALID, // Write response valid
   input wire logic I_BREADY, // Write response ready
   input wire logic [11:0] I_ARADDR, // Read address
   input wire logic I_ARVALID, // Read address valid
   output logic O_ARREADY, // Read address ready
   output logic [31:0] O_RDATA, // Read data
   output logic [1:0] O_RRESP, // Read response
   output logic O_RVALID, // Read data valid
   input wire logic I_RREADY, // Read data ready
   output logic [15:0] O_DATA_ADDR, // Last effective address
   output logic O_ADDR_VALID, // One-cycle pulse when an address is ready
   output logic O_BUSY // Generation under way
);
   if (MEM_AW < 8 || MEM_AW > 16) begin : g_bad_aw
      $error("MEM_AW must lie between 8 and 16");
   end

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rmux, wdata_q, wmask;
   logic [3:0] wstrb_q;
   logic [9:0] widx_q, ridx;
   logic wr_en, wmap, rmap;

   // A write commits once both address and data are held
   assign wr_en = !awready_q && !wready_q && !bvalid_q;
   assign ridx = I_ARADDR[11:2];

   // Byte strobes widened into a bit mask
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wstrb_q[b]}};
      end
   end

   // Write address and data are taken in either order
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `OAG_RESP_OKAY;
         widx_q <= 10'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (I_CE) begin
         if (I_AWVALID && awready_q) begin
            awready_q <= 1'b0;
            widx_q <= I_AWADDR[11:2];
         end
         if (I_WVALID && wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= I_WDATA;
            wstrb_q <= I_WSTRB;
         end
         if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q <= wmap ? `OAG_RESP_OKAY : `OAG_RESP_SLVERR;
         end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Read answers one cycle after the address is taken
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `OAG_RESP_OKAY;
      end else if (I_CE) begin
         if (I_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rmux;
            rresp_q <= rmap ? `OAG_RESP_OKAY : `OAG_RESP_SLVERR;
         end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   mode_e mode_q;
   opc_e opc_q;
   logic pen_q, start;
   logic [7:0] page_q, op1_q, op2_q, x_q, y_q, val_q;
   logic [15:0] ea_q, maddr_q;
   logic busy_q, done_q, bad_q, isval_q, noaddr_q, rmw_q, tgt_q;
   logic [31:0] ctrl_w, idx_w, opnd_w;
   logic x_inc;

   assign ctrl_w = {23'h000000, pen_q, 1'b0, opc_q, mode_q};
   assign idx_w = {16'h0000, y_q, x_q};
   assign opnd_w = {16'h0000, op2_q, op1_q};
   assign wmap = (widx_q == `OAG_IDX_CTRL) || (widx_q == `OAG_IDX_OPERAND) ||
      (widx_q == `OAG_IDX_INDEX) || (widx_q == `OAG_IDX_RESULT) ||
      (widx_q == `OAG_IDX_STATUS) || (widx_q == `OAG_IDX_MEMADDR) ||
      (widx_q == `OAG_IDX_MEMDATA) || (widx_q == `OAG_IDX_PAGE);
   // Start is refused while a generation is under way
   assign start = wr_en && (widx_q == `OAG_IDX_CTRL) && wstrb_q[3] &&
      wdata_q[`OAG_CTRL_START_BIT] && !busy_q;

   // Read multiplexer; result and status are read-only
   always_comb begin
      rmap = 1'b1;
      case (ridx)
         `OAG_IDX_CTRL: rmux = ctrl_w;
         `OAG_IDX_OPERAND: rmux = opnd_w;
         `OAG_IDX_INDEX: rmux = idx_w;
         `OAG_IDX_RESULT: rmux = {8'h00, val_q, ea_q};
         `OAG_IDX_STATUS: rmux = {25'h0000000, tgt_q, rmw_q, noaddr_q, isval_q,
            bad_q, done_q, busy_q};
         `OAG_IDX_MEMADDR: rmux = {16'h0000, maddr_q};
         `OAG_IDX_MEMDATA: rmux = 32'h0000_0000;
         `OAG_IDX_PAGE: rmux = {24'h000000, page_q};
         default: begin
            rmux = 32'h0000_0000;
            rmap = 1'b0;
         end
      endcase
   end

   // Control, operand and page registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         mode_q <= M_REG;
         opc_q <= OP_OTHER;
         pen_q <= 1'b0;
         op1_q <= `OAG_BYTE_RST;
         op2_q <= `OAG_BYTE_RST;
         page_q <= `OAG_PAGE_RST;
         maddr_q <= `OAG_WORD_RST;
      end else if (I_CE && wr_en) begin
         case (widx_q)
            `OAG_IDX_CTRL: begin
               mode_q <= mode_e'(((ctrl_w & ~wmask) | (wdata_q & wmask)) >> `OAG_CTRL_MODE_LSB);
               opc_q <= opc_e'(((ctrl_w & ~wmask) | (wdata_q & wmask)) >> `OAG_CTRL_OP_LSB);
               pen_q <= wstrb_q[1] ? wdata_q[`OAG_CTRL_PEN_BIT] : pen_q;
            end
            `OAG_IDX_OPERAND: {op2_q, op1_q} <= 16'((opnd_w & ~wmask) | (wdata_q & wmask));
            `OAG_IDX_PAGE: page_q <= wstrb_q[0] ? wdata_q[7:0] : page_q;
            `OAG_IDX_MEMADDR: maddr_q <= 16'(wdata_q & wmask);
            default: ;
         endcase
      end
   end

   // Index registers; a software write wins over the increment
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         x_q <= `OAG_BYTE_RST;
         y_q <= `OAG_BYTE_RST;
      end else if (I_CE) begin
         if (wr_en && widx_q == `OAG_IDX_INDEX) begin
            {y_q, x_q} <= 16'((idx_w & ~wmask) | (wdata_q & wmask));
         end else if (x_inc) begin
            x_q <= x_q + 8'h01; // RQ9 RQ18
         end
      end
   end

   // ************************************************************
   // Address formation
   // ************************************************************
   oag_mem_if #(.AW(MEM_AW)) mbus ();
   fsm_e st_q;
   logic [7:0] page, lo_q;
   logic [15:0] ea_c, ptr_c, ptr_q;
   logic ind_c, noaddr_c, isval_c, bad_c, xinc_c, rmw_c, addy_q;

   // Page byte is zero unless paging is enabled
   always_comb begin
      page = pen_q ? page_q : 8'h00;
      ea_c = 16'h0000;
      ptr_c = 16'h0000;
      ind_c = 1'b0;
      noaddr_c = 1'b0;
      isval_c = 1'b0;
      xinc_c = 1'b0;
      rmw_c = (mode_q == M_ABS) || (mode_q == M_DPX); // RQ7
      bad_c = (opc_q == OP_RMW) && !rmw_c; // RQ7
      case (mode_q)
         M_REG: noaddr_c = 1'b1; // RQ1
         M_IMM: begin
            isval_c = !pen_q; // RQ2
            noaddr_c = !pen_q;
            ea_c = {page_q, op1_q}; // RQ3 RQ17
         end
         M_DP: ea_c = {page, op1_q}; // RQ4 RQ17
         M_ABS: ea_c = {op2_q, op1_q}; // RQ5 RQ6
         M_X0: ea_c = {page, x_q}; // RQ8
         M_XINC: begin
            ea_c = {page, x_q};
            xinc_c = 1'b1; // RQ9
            bad_c = bad_c || !(opc_q == OP_LOAD || opc_q == OP_STORE); // RQ9
         end
         M_DPX: ea_c = {page, op1_q + x_q}; // RQ10 RQ18
         M_DPY: ea_c = {page, op1_q + y_q}; // RQ11 RQ18
         M_ABSY: ea_c = {op2_q, op1_q} + {8'h00, y_q}; // RQ12
         M_DPIND: begin
            ind_c = 1'b1;
            ptr_c = {page, op1_q}; // RQ13
            bad_c = bad_c || (opc_q != OP_JUMP); // RQ13
         end
         M_DPXIND: begin
            ind_c = 1'b1;
            ptr_c = {page, op1_q + x_q}; // RQ14 RQ18
         end
         M_DPINDY: begin
            ind_c = 1'b1;
            ptr_c = {page, op1_q}; // RQ15
         end
         M_ABSIND: begin
            ind_c = 1'b1;
            ptr_c = {op2_q, op1_q}; // RQ16
            bad_c = bad_c || (opc_q != OP_JUMP); // RQ16
         end
         default: bad_c = 1'b1;
      endcase
   end

   // Pointer high byte sits on the next location, wrapping in page except in absolute indirect mode
   assign mbus.re = (start && ind_c && !bad_c) || (st_q == S_LO);
   assign mbus.raddr = MEM_AW'((st_q == S_LO) ?
      ((mode_q == M_ABSIND) ? ptr_q + 16'h0001 : {ptr_q[15:8], ptr_q[7:0] + 8'h01}) :
      ptr_c); // RQ14 RQ15 RQ18
   assign mbus.we = wr_en && (widx_q == `OAG_IDX_MEMDATA) && wstrb_q[0];
   assign mbus.waddr = MEM_AW'(maddr_q);
   assign mbus.wdata = wdata_q[7:0];
   assign x_inc = start && xinc_c && !bad_c;

   oag_page_mem #(.AW(MEM_AW)) u_mem (
      .i_clk(I_CLK),
      .i_ce(I_CE),
      .bus(mbus)
   );

   // Sequencer: direct modes finish at once, indirect after two reads
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_q <= S_IDLE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         bad_q <= 1'b0;
         isval_q <= 1'b0;
         noaddr_q <= 1'b0;
         rmw_q <= 1'b0;
         tgt_q <= 1'b0;
         ea_q <= `OAG_WORD_RST;
         val_q <= `OAG_BYTE_RST;
         ptr_q <= `OAG_WORD_RST;
         lo_q <= `OAG_BYTE_RST;
         addy_q <= 1'b0;
         O_ADDR_VALID <= 1'b0;
      end else if (I_CE) begin
         O_ADDR_VALID <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (start) begin
                  done_q <= 1'b0;
                  bad_q <= bad_c;
                  isval_q <= isval_c && !bad_c;
                  noaddr_q <= noaddr_c || bad_c;
                  rmw_q <= rmw_c;
                  tgt_q <= (opc_q == OP_JUMP) && !bad_c;
                  val_q <= op1_q; // RQ2
                  ptr_q <= ptr_c;
                  addy_q <= (mode_q == M_DPINDY);
                  if (ind_c && !bad_c) begin
                     st_q <= S_LO;
                     busy_q <= 1'b1;
                  end else begin
                     done_q <= 1'b1;
                     O_ADDR_VALID <= !bad_c && !noaddr_c;
                     // Address only moves together with its pulse
                     if (!bad_c && !noaddr_c) begin
                        ea_q <= ea_c;
                     end
                  end
               end
            end
            S_LO: begin
               lo_q <= mbus.rdata; // Pointer low byte
               st_q <= S_HI;
            end
            S_HI: begin
               ea_q <= {mbus.rdata, lo_q} + (addy_q ? {8'h00, y_q} : 16'h0000); // RQ15
               done_q <= 1'b1;
               busy_q <= 1'b0;
               O_ADDR_VALID <= 1'b1;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   assign O_AWREADY = awready_q;
   assign O_WREADY = wready_q;
   assign O_BVALID = bvalid_q;
   assign O_BRESP = bresp_q;
   assign O_ARREADY = arready_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA = rdata_q;
   assign O_RRESP = rresp_q;
   assign O_DATA_ADDR = ea_q;
   assign O_BUSY = busy_q;
endmodule // operand_address_generator
`default_nettype wire

//--- test/oag_chk_sva.sv
// Checker of bus handshakes and address timing of the generator
`timescale 1ns/1ps
`default_nettype none
module oag_chk (
   input wire logic I_CLK, // Core clock
   input wire logic I_RST, // Reset
   input wire logic I_AWVALID, // Write address valid
   input wire logic O_AWREADY, // Write address ready
   input wire logic I_WVALID, // Write data valid
   input wire logic O_WREADY, // Write data ready
   input wire logic O_BVALID, // Response valid
   input wire logic I_BREADY, // Response ready
   input wire logic I_ARVALID, // Read address valid
   input wire logic O_ARREADY, // Read address ready
   input wire logic [31:0] O_RDATA, // Read data
   input wire logic O_RVALID, // Read valid
   input wire logic I_RREADY, // Read ready
   input wire logic [15:0] O_DATA_ADDR, // Effective address
   input wire logic O_ADDR_VALID, // Address pulse
   input wire logic O_BUSY // Pointer fetch
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // Commit waits for both readies to drop, so the answer shows two edges on
   property p_bresp;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response late");
   property p_bhold;
      O_BVALID && !I_BREADY |=> O_BVALID;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_bdone;
      O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write channel not freed");
   property p_rresp;
      I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
   endproperty
   a_rresp: assert property (p_rresp) else $error("read answer late");
   property p_rhold;
      O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_pulse;
      O_ADDR_VALID |=> !O_ADDR_VALID;
   endproperty
   a_pulse: assert property (p_pulse) else $error("address pulse too long");
   property p_addr;
      $changed(O_DATA_ADDR) |-> O_ADDR_VALID;
   endproperty
   a_addr: assert property (p_addr) else $error("address moved without pulse");
   // Two pointer bytes take two busy cycles, then the address
   property p_fetch;
      $rose(O_BUSY) |-> O_BUSY ##1 O_BUSY ##1 (!O_BUSY && O_ADDR_VALID);
   endproperty
   a_fetch: assert property (p_fetch) else $error("pointer fetch timing");
endmodule // oag_chk
bind operand_address_generator oag_chk oag_chk_i (.I_CLK(I_CLK), .I_RST(I_RST),
   .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
   .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
   .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_DATA_ADDR(O_DATA_ADDR),
   .O_ADDR_VALID(O_ADDR_VALID), .O_BUSY(O_BUSY));
`default_nettype wire

//--- test/oag_seq_model.sv
// Sequencer model that takes each effective address from the generator
`timescale 1ns/1ps
`default_nettype none
module oag_seq_model (
   input wire logic i_clk, // Core clock
   input wire logic i_rst, // Reset, active high
   input wire logic i_addr_valid, // Address pulse
   input wire logic [15:0] i_data_addr, // Effective address
   output logic [15:0] o_target, // Last address taken
   output logic [7:0] o_taken // Addresses taken
);
   // ****
   // Capture
   // ****
   // Pulse stands one cycle only, so a missed edge would lose the address
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_target <= 16'h0000;
         o_taken <= 8'h00;
      end else if (i_addr_valid) begin
         o_target <= i_data_addr;
         o_taken <= o_taken + 8'h01;
      end
   end
endmodule // oag_seq_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench of the operand address generator
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top
   import oag_pkg::*;
;
   logic I_CLK = 1'h0;
   logic I_RST = 1'h1;
   logic I_CE = 1'h1;
   logic [11:0] I_AWADDR = 12'h000;
   logic [11:0] I_ARADDR = 12'h000;
   logic [31:0] I_WDATA = 32'h0;
   logic [3:0] I_WSTRB = 4'h0;
   logic I_AWVALID = 1'h0;
   logic I_WVALID = 1'h0;
   logic I_BREADY = 1'h0;
   logic I_ARVALID = 1'h0;
   logic I_RREADY = 1'h0;
   logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_ADDR_VALID, O_BUSY;
   logic [1:0] O_BRESP, O_RRESP;
   logic [31:0] O_RDATA;
   logic [15:0] O_DATA_ADDR, target;
   logic [7:0] taken;
   int fail_count = 0;
   int comparisons = 0;
   // ****
   // Instances
   // ****
   operand_address_generator #(.MEM_AW(16)) operand_address_generator_i (.I_CLK(I_CLK),
      .I_RST(I_RST), .I_CE(I_CE), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
      .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID),
      .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
      .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
      .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
      .O_DATA_ADDR(O_DATA_ADDR), .O_ADDR_VALID(O_ADDR_VALID), .O_BUSY(O_BUSY));
   oag_seq_model oag_seq_model_i (.i_clk(I_CLK), .i_rst(I_RST), .i_addr_valid(O_ADDR_VALID),
      .i_data_addr(O_DATA_ADDR), .o_target(target), .o_taken(taken));
   // Free-running core clock
   always #5 I_CLK = ~I_CLK;
   // ****
   // Bus tasks
   // ****
   // Ready is raised only once the answer shows, so the slave must hold it
   task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] resp);
      @(posedge I_CLK);
      I_AWADDR <= {idx, 2'h0};
      I_WDATA <= d;
      I_WSTRB <= 4'hF;
      I_AWVALID <= 1'h1;
      I_WVALID <= 1'h1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge I_CLK);
         if (O_AWREADY) I_AWVALID <= 1'h0;
         if (O_WREADY) I_WVALID <= 1'h0;
         if (O_BVALID) I_BREADY <= 1'h1;
      end while (!(O_BVALID && I_BREADY));
      I_BREADY <= 1'h0;
      `CHK("bresp", resp, O_BRESP)
   endtask
   task automatic rd(input logic [9:0] idx, output logic [31:0] d, input logic [1:0] resp);
      @(posedge I_CLK);
      I_ARADDR <= {idx, 2'h0};
      I_ARVALID <= 1'h1;
      do begin
         @(posedge I_CLK);
         if (O_ARREADY) I_ARVALID <= 1'h0;
         if (O_RVALID) I_RREADY <= 1'h1;
      end while (!(O_RVALID && I_RREADY));
      d = O_RDATA;
      I_RREADY <= 1'h0;
      `CHK("rresp", resp, O_RRESP)
   endtask
   // Fields go in one write and start in the next, as a start write may ignore them
   task automatic gen(input mode_e m, input opc_e o, input logic pen, input logic hit,
                      input logic [15:0] a);
      logic [7:0] k;
      int n;
      wr(`OAG_IDX_CTRL, {23'h0, pen, 1'h0, o, m}, `OAG_RESP_OKAY);
      k = taken;
      wr(`OAG_IDX_CTRL, {1'h1, 22'h0, pen, 1'h0, o, m}, `OAG_RESP_OKAY);
      n = 0;
      while (taken == k && n < 8) begin
         @(posedge I_CLK);
         n++;
      end
      `CHK("pulses", {7'h0, hit}, taken - k)
      if (hit) begin
         `CHK("target", a, target)
         `CHK("port address", a, O_DATA_ADDR)
      end
   endtask
   task automatic mem(input logic [15:0] a, input logic [7:0] b);
      wr(`OAG_IDX_MEMADDR, {16'h0, a}, `OAG_RESP_OKAY);
      wr(`OAG_IDX_MEMDATA, {24'h0, b}, `OAG_RESP_OKAY);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      logic [31:0] d;
      rd(`OAG_IDX_PAGE, d, `OAG_RESP_OKAY);
      `CHK("page reset", 32'h0, d)
      wr(`OAG_IDX_PAGE, 32'hFFFFFFFF, `OAG_RESP_OKAY);
      rd(`OAG_IDX_PAGE, d, `OAG_RESP_OKAY);
      `CHK("page width", 32'h000000FF, d)
      wr(10'h0F0, 32'h1, `OAG_RESP_SLVERR);
      rd(10'h0F0, d, `OAG_RESP_SLVERR);
      `CHK("unmapped", 32'h0, d)
   endtask
   task automatic t_direct;
      logic [31:0] d;
      wr(`OAG_IDX_PAGE, 32'h3, `OAG_RESP_OKAY);
      wr(`OAG_IDX_OPERAND, 32'h0135, `OAG_RESP_OKAY);
      gen(M_REG, OP_OTHER, 1'h1, 1'h0, 16'h0000);
      rd(`OAG_IDX_STATUS, d, `OAG_RESP_OKAY);
      `CHK("no address", 1'h1, d[`OAG_ST_NOADDR])
      gen(M_IMM, OP_LOAD, 1'h0, 1'h0, 16'h0000);
      rd(`OAG_IDX_RESULT, d, `OAG_RESP_OKAY);
      `CHK("immediate", 8'h35, d[23:16])
      rd(`OAG_IDX_STATUS, d, `OAG_RESP_OKAY);
      `CHK("value only", 1'h1, d[`OAG_ST_VALUE])
      gen(M_IMM, OP_LOAD, 1'h1, 1'h1, 16'h0335);
      gen(M_DP, OP_LOAD, 1'h0, 1'h1, 16'h0035);
      gen(M_DP, OP_STORE, 1'h1, 1'h1, 16'h0335);
      gen(M_ABS, OP_RMW, 1'h1, 1'h1, 16'h0135);
      rd(`OAG_IDX_STATUS, d, `OAG_RESP_OKAY);
      `CHK("rmw allowed", 1'h1, d[`OAG_ST_RMW])
      gen(M_ABS, OP_LOAD, 1'h0, 1'h1, 16'h0135);
      gen(M_DP, OP_RMW, 1'h1, 1'h0, 16'h0000);
      rd(`OAG_IDX_STATUS, d, `OAG_RESP_OKAY);
      `CHK("illegal", 1'h1, d[`OAG_ST_ILLEGAL])
   endtask
   task automatic t_indexed;
      logic [31:0] d;
      wr(`OAG_IDX_OPERAND, 32'h01F0, `OAG_RESP_OKAY);
      wr(`OAG_IDX_INDEX, 32'h20FF, `OAG_RESP_OKAY);
      gen(M_X0, OP_LOAD, 1'h1, 1'h1, 16'h03FF);
      gen(M_XINC, OP_STORE, 1'h1, 1'h1, 16'h03FF);
      rd(`OAG_IDX_INDEX, d, `OAG_RESP_OKAY);
      `CHK("x after step", 16'h2000, d[15:0])
      gen(M_XINC, OP_OTHER, 1'h1, 1'h0, 16'h0000);
      wr(`OAG_IDX_INDEX, 32'h20FF, `OAG_RESP_OKAY);
      gen(M_DPX, OP_LOAD, 1'h1, 1'h1, 16'h03EF);
      gen(M_DPY, OP_LOAD, 1'h1, 1'h1, 16'h0310);
      gen(M_ABSY, OP_LOAD, 1'h1, 1'h1, 16'h0210);
   endtask
   // Pointers straddle the page end and a page boundary of the full space
   task automatic t_indirect;
      logic [31:0] d;
      wr(`OAG_IDX_OPERAND, 32'h12FF, `OAG_RESP_OKAY);
      wr(`OAG_IDX_INDEX, 32'h1002, `OAG_RESP_OKAY);
      mem(16'h03FF, 8'h34);
      mem(16'h0300, 8'h56);
      mem(16'h0301, 8'h78);
      mem(16'h0302, 8'h9A);
      mem(16'h12FF, 8'hBC);
      mem(16'h1300, 8'hDE);
      gen(M_DPIND, OP_JUMP, 1'h1, 1'h1, 16'h5634);
      gen(M_DPIND, OP_LOAD, 1'h1, 1'h0, 16'h0000);
      gen(M_DPXIND, OP_LOAD, 1'h1, 1'h1, 16'h9A78);
      gen(M_DPINDY, OP_LOAD, 1'h1, 1'h1, 16'h5644);
      gen(M_ABSIND, OP_JUMP, 1'h1, 1'h1, 16'hDEBC);
      rd(`OAG_IDX_STATUS, d, `OAG_RESP_OKAY);
      `CHK("jump target", 1'h1, d[`OAG_ST_TARGET])
      `CHK("done", 1'h1, d[`OAG_ST_DONE])
      `CHK("busy after fetch", 1'h0, d[`OAG_ST_BUSY])
   endtask
   task automatic stop_test;
      $display("Mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ****
   // Sequence
   // ****
   // Reset for five cycles, then every scenario in turn
   initial begin
      repeat (5) @(posedge I_CLK);
      I_RST <= 1'h0;
      t_regs;
      t_direct;
      t_indexed;
      t_indirect;
      stop_test;
   end
   // Watchdog well beyond the roughly four hundred cycles the scenarios need
   initial begin
      repeat (6000) @(posedge I_CLK);
      fail_count++;
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
